// ---- core/nhf_frame_core.sv ----
// Function
// - good frame reports code 0x80
// - user abort code only in card mode
// - frame wait timeout gives 0x87
// - buffer overrun gives 0x89
// - character framing fault gives 0x8A
// - short length and crc codes for 18092
// - lost reception gives 0x8E
// - listen without field gives 0x8F
// - partial last byte sets bit 4 of 0x80; 0x90 unused
// - disturbance and guard time codes passed
// - accept 528 or 526 reply bytes
// - code, length, data order both ways
// - 10-bit reply count split across bytes
// - residual flag bit 4, type A only
// - one-byte fields, data up to 253
// - echo is a lone 0x55 byte
// - decode identity, protocol, field query
// - decode transceive, listen, transmit only
// - decode low power wait, register read
// - decode configuration register write
// - decode subcarrier, filter; rest reserved
// - echo replies or aborts active listen
// - control byte selects transaction type
// - poll flags: bit3 readable, bit2 sendable
`timescale 1ns/1ps
`default_nettype none
module nhf_frame_core
	import nhf_pkg::*;
#(
	parameter int ADDR_W   = 12,
	parameter int TX_DEPTH = 253,
	parameter int RX_DEPTH = 528
) (
	// clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// rf engine command side
	output logic                   eng_start,
	output logic      [3:0]        eng_op,
	output logic      [7:0]        eng_tx_len,
	input  wire logic [7:0]        eng_tx_addr,
	output logic      [7:0]        eng_tx_data,
	output logic                   eng_abort,
	output logic                   dev_reset,
	// rf engine reply side
	input  wire logic              eng_rx_we,
	input  wire logic [7:0]        eng_rx_data,
	input  wire logic              eng_residual,
	input  wire logic              eng_done,
	input  wire logic [3:0]        eng_evt,
	// protocol context
	input  wire logic              proto_nfc,
	input  wire logic              proto_typea,
	input  wire logic              card_mode
);
	typedef struct packed {
		nhf_state_e  state;
		logic        open;
		logic [7:0]  sess;
		logic        listen;
		logic        pend;
		logic [7:0]  code;
		logic [7:0]  len;
		logic [7:0]  idx;
		logic [9:0]  cnt;
		logic        over;
		logic [7:0]  res;
		logic [9:0]  rlen;
		logic [9:0]  rdi;
		logic        single;
		logic [31:0] prdata;
		logic [7:0]  txd;
		logic        start;
		logic [3:0]  op;
		logic        abort;
		logic        rst;
	} nhf_core_s;

	nhf_core_s r_q;
	nhf_core_s r_d;
	logic [7:0] tx_mem [TX_DEPTH];
	logic [7:0] rx_mem [RX_DEPTH];
	logic       tx_we;
	logic [7:0] tx_wa;
	logic       rx_we;
	logic [7:0] wr_byte;
	logic [7:0] flags;
	logic [9:0] total;
	logic [9:0] limit;
	logic [7:0] reply_byte;
	logic [31:0] rd_word;
	logic       setup;
	logic       acc;
	logic       can_send;

	nhf_ctl_if ctl ();

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [11:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	nhf_cmd_decode u_dec (
		.ctl (ctl.dec)
	);

	nhf_reply_fmt u_fmt (
		.ctl (ctl.fmt)
	);

	// feed the decoder and the result formatter
	assign ctl.code   = r_q.code;
	assign ctl.evt    = nhf_evt_e'(eng_evt);
	assign ctl.cnt    = r_q.cnt;
	assign ctl.resid  = eng_residual;
	assign ctl.nfc    = proto_nfc;
	assign ctl.typea  = proto_typea;
	assign ctl.card   = card_mode;
	assign ctl.listen = r_q.listen;
	assign ctl.over   = r_q.over;

	// apb handshake and outputs
	assign pready      = 1'b1;
	assign pslverr     = psel & penable & ~(hit(paddr, REG_SESSION)
		| hit(paddr, REG_CLOSE) | hit(paddr, REG_DATA)
		| hit(paddr, REG_STATUS));
	assign prdata      = r_q.prdata;
	assign eng_start   = r_q.start;
	assign eng_op      = r_q.op;
	assign eng_tx_len  = r_q.len;
	assign eng_tx_data = r_q.txd;
	assign eng_abort   = r_q.abort;
	assign dev_reset   = r_q.rst;
	assign setup       = psel & ~penable;
	assign acc         = psel & penable;
	assign wr_byte     = pwdata[7:0];

	// readiness flags and reply geometry
	always_comb begin
		can_send = (r_q.state == ST_READY) | (r_q.state == ST_BUSY
			& r_q.listen);
		flags = 8'h00;
		flags[FLAG_CAN_READ] = (r_q.state == ST_REPLY);
		flags[FLAG_CAN_SEND] = can_send & ~r_q.pend;
		total = r_q.single ? 10'd1 : 10'(r_q.rlen + 10'd2);
		limit = proto_typea ? RX_MAX_TYPEA : RX_MAX_LONG;
	end

	// reply stream: result, length low byte, data
	always_comb begin
		if (r_q.rdi >= total) begin
			reply_byte = 8'h00;
		end else if (r_q.rdi == 10'd0) begin
			reply_byte = r_q.res;
		end else if (r_q.rdi == 10'd1) begin
			reply_byte = r_q.rlen[7:0];
		end else begin
			reply_byte = rx_mem[10'(r_q.rdi - 10'd2)];
		end
	end

	// read mux, captured in the setup phase
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit(paddr, REG_STATUS)) begin
			rd_word[7:0] = flags;
			rd_word[STAT_OPEN_BIT] = r_q.open;
			rd_word[STAT_LISTEN_BIT] = r_q.listen;
		end else if (hit(paddr, REG_DATA) && r_q.open) begin
			if (r_q.sess == CTL_POLL) begin
				rd_word[7:0] = flags;
			end else if (r_q.sess == CTL_READ && r_q.state == ST_REPLY) begin
				rd_word[7:0] = reply_byte;
			end
		end
	end

	// next state
	always_comb begin
		r_d = r_q;
		r_d.start = 1'b0;
		r_d.abort = 1'b0;
		r_d.rst = 1'b0;
		tx_we = 1'b0;
		tx_wa = 8'h00;
		rx_we = 1'b0;
		r_d.txd = (32'(eng_tx_addr) < TX_DEPTH) ? tx_mem[eng_tx_addr] : 8'h00;
		if (setup && !pwrite) begin
			r_d.prdata = rd_word;
		end
		// engine reply collection
		if (r_q.state == ST_BUSY) begin
			if (eng_rx_we) begin
				if (r_q.cnt >= limit) begin
					r_d.over = 1'b1;
				end else begin
					rx_we = 1'b1;
					r_d.cnt = 10'(r_q.cnt + 10'd1);
				end
			end
			if (eng_done) begin
				r_d.res = ctl.result;
				r_d.rlen = (ctl.result[3:0] == 4'h0) ? r_q.cnt : 10'd0;
				r_d.rdi = 10'd0;
				r_d.single = 1'b0;
				r_d.listen = 1'b0;
				r_d.state = ST_REPLY;
			end
		end
		// act on a complete host frame
		if (r_q.pend) begin
			r_d.pend = 1'b0;
			if (r_q.state == ST_READY) begin
				r_d.rdi = 10'd0;
				if (ctl.reserved || r_q.len > MAX_DATA) begin
					r_d.res = RC_REJECT;
					r_d.rlen = 10'd0;
					r_d.single = 1'b0;
					r_d.state = ST_REPLY;
				end else if (ctl.op == OP_ECHO) begin
					r_d.res = CMD_ECHO;
					r_d.single = 1'b1;
					r_d.state = ST_REPLY;
				end else begin
					r_d.start = 1'b1;
					r_d.op = ctl.op;
					r_d.listen = (ctl.op == OP_LISTEN);
					r_d.cnt = 10'd0;
					r_d.over = 1'b0;
					r_d.state = ST_BUSY;
				end
			end else if (r_q.state == ST_BUSY && r_q.listen
				&& ctl.op == OP_ECHO && !eng_done) begin
				r_d.abort = 1'b1;
			end
		end
		// register writes in the access phase
		if (acc && pwrite) begin
			if (hit(paddr, REG_SESSION)) begin
				if (!r_q.open) begin
					r_d.open = 1'b1;
					r_d.sess = wr_byte;
					r_d.idx = 8'h00;
				end
			end else if (hit(paddr, REG_CLOSE)) begin
				if (r_q.open) begin
					r_d.open = 1'b0;
					r_d.idx = 8'h00;
					if (r_q.sess == CTL_RESET) begin
						r_d = '0;
						r_d.rst = 1'b1;
					end else if (r_q.sess == CTL_READ
						&& r_q.state == ST_REPLY && r_q.rdi >= total) begin
						r_d.state = ST_READY;
					end
				end
			end else if (hit(paddr, REG_DATA) && r_q.open
				&& r_q.sess == CTL_SEND && can_send && !r_q.pend) begin
				// host frame: code, length, data
				if (r_q.idx == 8'h00) begin
					r_d.code = wr_byte;
					r_d.len = 8'h00;
					if (wr_byte == CMD_ECHO) begin
						r_d.pend = 1'b1;
					end else begin
						r_d.idx = 8'h01;
					end
				end else if (r_q.idx == 8'h01) begin
					r_d.len = wr_byte;
					if (wr_byte == 8'h00 || wr_byte > MAX_DATA) begin
						r_d.pend = 1'b1;
					end else begin
						r_d.idx = 8'h02;
					end
				end else begin
					tx_we = 1'b1;
					tx_wa = 8'(r_q.idx - 8'd2);
					r_d.idx = 8'(r_q.idx + 8'd1);
					if (8'(r_q.idx - 8'd1) == r_q.len) begin
						r_d.pend = 1'b1;
					end
				end
			end
		end
		// reply pop on a data read
		if (acc && !pwrite && hit(paddr, REG_DATA) && r_q.open
			&& r_q.sess == CTL_READ && r_q.state == ST_REPLY
			&& r_q.rdi < total) begin
			r_d.rdi = 10'(r_q.rdi + 10'd1);
		end
		// a send session closed mid-frame drops the partial frame
		if (!r_d.open && r_q.open && !r_d.pend && r_q.sess == CTL_SEND) begin
			r_d.idx = 8'h00;
		end
	end

	// frame buffers
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (tx_we) begin
				tx_mem[tx_wa] <= wr_byte;
			end
			if (rx_we) begin
				rx_mem[r_q.cnt] <= eng_rx_data;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
		end else if (ce) begin
			r_q <= r_d;
		end
	end
endmodule
`default_nettype wire

// ---- core/nhf_pkg.sv ----
package nhf_pkg;
	// register byte offsets
	localparam logic [11:0] REG_SESSION = 12'h000;
	localparam logic [11:0] REG_CLOSE   = 12'h004;
	localparam logic [11:0] REG_DATA    = 12'h008;
	localparam logic [11:0] REG_STATUS  = 12'h00C;
	// transaction control bytes
	localparam logic [7:0] CTL_SEND  = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h01;
	localparam logic [7:0] CTL_READ  = 8'h02;
	localparam logic [7:0] CTL_POLL  = 8'h03;
	// readiness flag and status bit positions
	localparam int FLAG_CAN_READ = 3;
	localparam int FLAG_CAN_SEND = 2;
	localparam int STAT_OPEN_BIT   = 8;
	localparam int STAT_LISTEN_BIT = 9;
	// command codes
	localparam logic [7:0] CMD_IDENTITY   = 8'h01;
	localparam logic [7:0] CMD_PROTOCOL   = 8'h02;
	localparam logic [7:0] CMD_FIELD_POLL = 8'h03;
	localparam logic [7:0] CMD_TX_RX      = 8'h04;
	localparam logic [7:0] CMD_LISTEN     = 8'h05;
	localparam logic [7:0] CMD_TX_ONLY    = 8'h06;
	localparam logic [7:0] CMD_LOW_POWER  = 8'h07;
	localparam logic [7:0] CMD_REG_READ   = 8'h08;
	localparam logic [7:0] CMD_REG_WRITE  = 8'h09;
	localparam logic [7:0] CMD_SUBCARRIER = 8'h0B;
	localparam logic [7:0] CMD_AC_FILTER  = 8'h0D;
	localparam logic [7:0] CMD_ECHO       = 8'h55;
	// result codes
	localparam logic [7:0] RC_FRAME_OK    = 8'h80;
	localparam logic [7:0] RC_USER_ABORT  = 8'h85;
	localparam logic [7:0] RC_HW_COMM     = 8'h86;
	localparam logic [7:0] RC_WAIT_TOUT   = 8'h87;
	localparam logic [7:0] RC_BAD_START   = 8'h88;
	localparam logic [7:0] RC_OVERRUN     = 8'h89;
	localparam logic [7:0] RC_FRAMING     = 8'h8A;
	localparam logic [7:0] RC_GUARD_TOUT  = 8'h8B;
	localparam logic [7:0] RC_BAD_LENGTH  = 8'h8C;
	localparam logic [7:0] RC_CRC_FAULT   = 8'h8D;
	localparam logic [7:0] RC_RX_LOST     = 8'h8E;
	localparam logic [7:0] RC_NO_FIELD    = 8'h8F;
	localparam logic [7:0] RC_PARTIAL     = 8'h90;
	localparam logic [7:0] RC_REJECT      = RC_HW_COMM;
	// result byte field positions
	localparam int RC_LEN9_BIT  = 6;
	localparam int RC_LEN8_BIT  = 5;
	localparam int RC_RESID_BIT = 4;
	// frame limits
	localparam logic [7:0] MAX_DATA     = 8'd253;
	localparam logic [9:0] RX_MAX_LONG  = 10'd528;
	localparam logic [9:0] RX_MAX_TYPEA = 10'd526;
	localparam logic [9:0] NFC_MIN_LEN  = 10'd3;
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000, OP_IDENTITY = 4'b0001, OP_PROTOCOL = 4'b0010,
		OP_FIELD_POLL = 4'b0011, OP_TX_RX = 4'b0100, OP_LISTEN = 4'b0101,
		OP_TX_ONLY = 4'b0110, OP_LOW_POWER = 4'b0111,
		OP_REG_READ = 4'b1000, OP_REG_WRITE = 4'b1001,
		OP_SUBCARRIER = 4'b1010, OP_AC_FILTER = 4'b1011,
		OP_ECHO = 4'b1100, OP_RESERVED = 4'b1111
	} nhf_op_e;
	typedef enum logic [3:0] {
		EV_OK = 4'b0000, EV_USER_STOP = 4'b0001, EV_COMM = 4'b0010,
		EV_WAIT_TOUT = 4'b0011, EV_BAD_START = 4'b0100,
		EV_FRAMING = 4'b0101, EV_GUARD = 4'b0110, EV_CRC = 4'b0111,
		EV_LOST = 4'b1000, EV_NO_FIELD = 4'b1001
	} nhf_evt_e;
	typedef enum logic [1:0] {
		ST_READY = 2'b00, ST_BUSY = 2'b01, ST_REPLY = 2'b10
	} nhf_state_e;
endpackage

// ---- core/nhf_ctl_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface nhf_ctl_if;
	import nhf_pkg::*;
	logic [7:0] code;
	nhf_op_e    op;
	logic       reserved;
	nhf_evt_e   evt;
	logic [9:0] cnt;
	logic       resid;
	logic       nfc;
	logic       typea;
	logic       card;
	logic       listen;
	logic       over;
	logic [7:0] result;
	modport dec (input code, output op, reserved);
	modport fmt (input evt, cnt, resid, nfc, typea, card, listen, over,
		output result);
	modport core (output code, evt, cnt, resid, nfc, typea, card, listen,
		over, input op, reserved, result);
endinterface
`default_nettype wire

// ---- core/nhf_cmd_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module nhf_cmd_decode
	import nhf_pkg::*;
(
	// command code in, operation out
	nhf_ctl_if.dec ctl
);
	// map command code onto engine operation
	always_comb begin
		ctl.reserved = 1'b0;
		case (ctl.code)
			CMD_IDENTITY:   ctl.op = OP_IDENTITY;
			CMD_PROTOCOL:   ctl.op = OP_PROTOCOL;
			CMD_FIELD_POLL: ctl.op = OP_FIELD_POLL;
			CMD_TX_RX:      ctl.op = OP_TX_RX;
			CMD_LISTEN:     ctl.op = OP_LISTEN;
			CMD_TX_ONLY:    ctl.op = OP_TX_ONLY;
			CMD_LOW_POWER:  ctl.op = OP_LOW_POWER;
			CMD_REG_READ:   ctl.op = OP_REG_READ;
			CMD_REG_WRITE:  ctl.op = OP_REG_WRITE;
			CMD_SUBCARRIER: ctl.op = OP_SUBCARRIER;
			CMD_AC_FILTER:  ctl.op = OP_AC_FILTER;
			CMD_ECHO:       ctl.op = OP_ECHO;
			default: begin
				ctl.op       = OP_RESERVED;
				ctl.reserved = 1'b1;
			end
		endcase
	end
endmodule
`default_nettype wire

// ---- core/nhf_reply_fmt.sv ----
`timescale 1ns/1ps
`default_nettype none
module nhf_reply_fmt
	import nhf_pkg::*;
(
	// engine outcome in, result byte out
	nhf_ctl_if.fmt ctl
);
	logic [7:0] ok_code;
	// good frame: long length bits and residual flag
	always_comb begin
		ok_code = RC_FRAME_OK;
		ok_code[RC_LEN9_BIT] = ctl.cnt[9];
		ok_code[RC_LEN8_BIT] = ctl.cnt[8];
		ok_code[RC_RESID_BIT] = ctl.resid & ctl.typea;
	end
	// overrun first, then the engine event
	always_comb begin
		if (ctl.over) begin
			ctl.result = RC_OVERRUN;
		end else begin
			case (ctl.evt)
				EV_OK: begin
					if (ctl.nfc && ctl.cnt < NFC_MIN_LEN) begin
						ctl.result = RC_BAD_LENGTH;
					end else begin
						ctl.result = ok_code;
					end
				end
				EV_USER_STOP: ctl.result = ctl.card ? RC_USER_ABORT
					: RC_HW_COMM;
				EV_COMM:      ctl.result = RC_HW_COMM;
				EV_WAIT_TOUT: ctl.result = RC_WAIT_TOUT;
				EV_BAD_START: ctl.result = RC_BAD_START;
				EV_FRAMING:   ctl.result = RC_FRAMING;
				EV_GUARD:     ctl.result = RC_GUARD_TOUT;
				EV_CRC:       ctl.result = ctl.nfc ? RC_CRC_FAULT
					: ok_code;
				EV_LOST:      ctl.result = RC_RX_LOST;
				EV_NO_FIELD:  ctl.result = ctl.listen ? RC_NO_FIELD
					: RC_HW_COMM;
				default:      ctl.result = RC_HW_COMM;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- verif/nhf_chk_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module nhf_chk
	import nhf_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// engine side
	input wire logic              eng_start,
	input wire logic [3:0]        eng_op,
	input wire logic [7:0]        eng_tx_len,
	input wire logic [7:0]        eng_tx_addr,
	input wire logic [7:0]        eng_tx_data,
	input wire logic              eng_abort,
	input wire logic              dev_reset
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase decode
	logic acc;
	logic hit;
	assign acc = psel && penable;
	assign hit = paddr inside {REG_SESSION, REG_CLOSE, REG_DATA, REG_STATUS};
	zero_wait_a: assert property (acc |-> pready)
		else $error("access not answered at once");
	unmapped_err_a: assert property (acc && !hit |-> pslverr
		&& (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && hit |-> !pslverr)
		else $error("mapped access refused");
	start_pulse_a: assert property (eng_start |=> !eng_start)
		else $error("start longer than one cycle");
	start_op_a: assert property (eng_start |->
		!(eng_op inside {OP_NONE, OP_ECHO, OP_RESERVED}))
		else $error("engine started on non engine code");
	start_len_a: assert property (eng_start |-> eng_tx_len <= MAX_DATA)
		else $error("frame length above limit");
	tx_tail_a: assert property (eng_tx_addr >= 8'd253
		|=> eng_tx_data == 8'h00)
		else $error("data beyond frame not zero");
	abort_listen_a: assert property (eng_abort
		|-> eng_op == OP_LISTEN && !eng_start)
		else $error("abort outside listen");
	flag_excl_a: assert property (acc && !pwrite && paddr == REG_STATUS |->
		!(prdata[3] && prdata[2]) && prdata[31:10] == 22'h0)
		else $error("status flags inconsistent");
	byte_read_a: assert property (acc && !pwrite && paddr == REG_DATA |->
		prdata[31:8] == 24'h0)
		else $error("data read wider than a byte");
	rst_pulse_a: assert property (dev_reset |=> !dev_reset)
		else $error("device reset longer than one cycle");
	c_start: cover property (eng_start);
	c_abort: cover property (eng_abort);
	c_reset: cover property (dev_reset);
	c_err: cover property (acc && pslverr);
endmodule
bind nhf_frame_core nhf_chk #(.ADDR_W(ADDR_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .eng_start(eng_start), .eng_op(eng_op),
	.eng_tx_len(eng_tx_len), .eng_tx_addr(eng_tx_addr),
	.eng_tx_data(eng_tx_data), .eng_abort(eng_abort), .dev_reset(dev_reset)
);
`default_nettype wire

// ---- verif/nhf_eng_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nhf_eng_model
	import nhf_pkg::*;
(
	// clock
	input wire logic        pclk,
	// command side
	input wire logic        eng_start,
	input wire logic [3:0]  eng_op,
	input wire logic [7:0]  eng_tx_len,
	output logic     [7:0]  eng_tx_addr,
	input wire logic [7:0]  eng_tx_data,
	input wire logic        eng_abort,
	// reply side
	output logic            eng_rx_we,
	output logic     [7:0]  eng_rx_data,
	output logic            eng_residual,
	output logic            eng_done,
	output logic     [3:0]  eng_evt,
	// scenario controls
	input wire logic [9:0]  cfg_cnt,
	input wire logic [3:0]  cfg_evt,
	input wire logic        cfg_res
);
	logic [7:0] len_q;
	logic [7:0] b;
	int         i;
	int         w;
	initial begin
		eng_tx_addr = 8'hFE;
		eng_rx_we = 1'b0;
		eng_rx_data = 8'h00;
		eng_residual = 1'b0;
		eng_done = 1'b0;
		eng_evt = 4'h0;
	end
	// one operation per start pulse, echoing frame data back
	always begin
		@(posedge pclk);
		if (eng_start === 1'b1) begin
			len_q = eng_tx_len;
			// a host stopped listen waits for the abort pulse
			if (eng_op == OP_LISTEN && cfg_evt == EV_USER_STOP) begin
				w = 0;
				while (eng_abort !== 1'b1 && w < 3000) begin
					@(posedge pclk);
					w++;
				end
			end
			for (i = 0; i < cfg_cnt; i++) begin
				b = i[7:0];
				if (i < len_q) begin
					eng_tx_addr <= i[7:0];
					@(posedge pclk);
					@(posedge pclk);
					b = eng_tx_data;
				end
				eng_rx_we <= 1'b1;
				eng_rx_data <= b;
				@(posedge pclk);
				eng_rx_we <= 1'b0;
				eng_rx_data <= ~b;
				eng_tx_addr <= 8'hFE;
				@(posedge pclk);
			end
			eng_evt <= cfg_evt;
			eng_residual <= cfg_res;
			eng_done <= 1'b1;
			@(posedge pclk);
			eng_done <= 1'b0;
			eng_residual <= ~cfg_res;
		end
	end
endmodule
`default_nettype wire

// ---- verif/nhf_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin \
	num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module testbench;
	import nhf_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, last_rd, exp_rd;
	logic pready, pslverr, eng_start, eng_abort, dev_reset, rx_we, resid;
	logic done, sb_on = 0, nfc = 0, typea = 0, card = 0, cfg_res = 0;
	logic [3:0] eng_op, evt, cfg_evt = 0;
	logic [7:0] tx_len, tx_addr, tx_data, rx_data, tx[0:252];
	logic [9:0] cfg_cnt = 0;
	logic [11:0] exp_op, opq[$];
	logic [31:0] expq[$];
	logic [7:0] cmds[11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h07, 8'h08, 8'h09, 8'h0B, 8'h0D};
	logic [3:0] ops[11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h9, 4'hA, 4'hB};
	int num_errors = 0, checks_done = 0, k, t, cur_len, n_rst = 0, n_abort = 0;
	// reserved codes below and inside the command range
	logic [7:0] rsv[3] = '{8'h00, 8'h0A, 8'h0C};
	logic last_err;
	always #5 pclk = ~pclk;
	nhf_frame_core dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eng_start(eng_start), .eng_op(eng_op),
		.eng_tx_len(tx_len), .eng_tx_addr(tx_addr), .eng_tx_data(tx_data),
		.eng_abort(eng_abort), .dev_reset(dev_reset), .eng_rx_we(rx_we),
		.eng_rx_data(rx_data), .eng_residual(resid), .eng_done(done),
		.eng_evt(evt), .proto_nfc(nfc), .proto_typea(typea),
		.card_mode(card));
	nhf_eng_model u_eng (.pclk(pclk), .eng_start(eng_start),
		.eng_op(eng_op), .eng_tx_len(tx_len), .eng_tx_addr(tx_addr),
		.eng_tx_data(tx_data), .eng_abort(eng_abort), .eng_rx_we(rx_we),
		.eng_rx_data(rx_data), .eng_residual(resid), .eng_done(done),
		.eng_evt(evt), .cfg_cnt(cfg_cnt), .cfg_evt(cfg_evt),
		.cfg_res(cfg_res));
	// scoreboard: read data and engine starts against notes
	always @(posedge pclk) begin
		if (dev_reset === 1'b1) n_rst++;
		if (eng_abort === 1'b1) n_abort++;
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && sb_on) begin
			exp_rd = expq.pop_front();
			`CHK("prdata", exp_rd, prdata)
		end
		if (eng_start === 1'b1) begin
			exp_op = opq.pop_front();
			`CHK("op_len", exp_op, {tx_len, eng_op})
		end
	end
	task give_verdict;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic c, input logic [31:0] e);
		if (c) expq.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		sb_on <= c;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		last_rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		sb_on <= 1'b0;
		@(posedge pclk);
	endtask
	task send(input logic [7:0] c, input int n, input logic lone);
		apb(REG_SESSION, 1, {24'h0, CTL_SEND}, 0, 0);
		apb(REG_DATA, 1, {24'h0, c}, 0, 0);
		if (!lone) apb(REG_DATA, 1, n, 0, 0);
		for (k = 0; k < n && n <= 253 && !lone; k++)
			apb(REG_DATA, 1, {24'h0, tx[k]}, 0, 0);
		apb(REG_CLOSE, 1, 0, 0, 0);
	endtask
	task reply(input logic [7:0] c, input int n, input logic lone);
		apb(REG_SESSION, 1, {24'h0, CTL_POLL}, 0, 0);
		k = 0;
		do begin
			apb(REG_DATA, 0, 0, 0, 0);
			k++;
		end while (last_rd[FLAG_CAN_READ] !== 1'b1 && k < 4000);
		apb(REG_CLOSE, 1, 0, 0, 0);
		apb(REG_SESSION, 1, {24'h0, CTL_READ}, 0, 0);
		apb(REG_DATA, 0, 0, 1, {24'h0, c});
		if (!lone) apb(REG_DATA, 0, 0, 1, n & 32'hFF);
		for (k = 0; k < n && !lone; k++)
			apb(REG_DATA, 0, 0, 1, {24'h0, k < cur_len ? tx[k] : k[7:0]});
		apb(REG_CLOSE, 1, 0, 0, 0);
	endtask
	task run(input logic [7:0] c, input int len, input logic [9:0] n,
		input logic [3:0] e, input logic r, input logic [7:0] rc,
		input logic [3:0] op);
		cfg_cnt <= n;
		cfg_evt <= e;
		cfg_res <= r;
		cur_len = len;
		for (k = 0; k < len; k++) tx[k] = 8'($urandom);
		opq.push_back({8'(len), op});
		send(c, len, 0);
		if (rc == 8'h00) reply({1'b1, n[9:8], r & typea, 4'h0}, n, 0);
		else reply(rc, 0, 0);
	endtask
	task ev(input logic [3:0] e, input logic f, input logic cm,
		input logic [3:0] op, input logic [9:0] n, input logic [7:0] rc);
		nfc <= f;
		card <= cm;
		run(op == OP_LISTEN ? CMD_LISTEN : CMD_TX_RX, 0, n, e, 0, rc, op);
	endtask
	// watchdog
	initial begin
		#800000;
		num_errors++;
		$display("watchdog expired");
		give_verdict;
	end
	// main sequence
	initial begin
		void'($urandom(32'h97a9));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(REG_STATUS, 0, 0, 1, 32'h4);
		apb(12'h010, 0, 0, 1, 32'h0);
		`CHK("pslverr", 1'b1, last_err)
		cur_len = 0;
		send(CMD_ECHO, 0, 1);
		reply(CMD_ECHO, 0, 1);
		$display("test reset and echo done");
		for (t = 0; t < 11; t++) run(cmds[t], $urandom_range(253, 0),
			10'($urandom_range(40, 0)), EV_OK, 0, 0, ops[t]);
		run(CMD_TX_RX, 253, 253, EV_OK, 0, 0, OP_TX_RX);
		$display("test command set done");
		for (t = 0; t < 4; t++) begin
			cur_len = 0;
			send(t == 3 ? 8'h0E + 8'($urandom_range(70, 0)) : rsv[t], 0, 0);
			reply(RC_REJECT, 0, 0);
		end
		send(CMD_IDENTITY, 254, 0);
		reply(RC_REJECT, 0, 0);
		$display("test rejection done");
		run(CMD_TX_RX, 0, 255, EV_OK, 0, 0, OP_TX_RX);
		run(CMD_TX_RX, 0, 256, EV_OK, 1, 0, OP_TX_RX);
		run(CMD_TX_RX, 0, 512, EV_OK, 0, 0, OP_TX_RX);
		run(CMD_TX_RX, 0, 528, EV_OK, 0, 0, OP_TX_RX);
		run(CMD_TX_RX, 0, 529, EV_OK, 0, RC_OVERRUN, OP_TX_RX);
		typea <= 1'b1;
		run(CMD_TX_RX, 0, 526, EV_OK, 0, 0, OP_TX_RX);
		run(CMD_TX_RX, 0, 527, EV_OK, 0, RC_OVERRUN, OP_TX_RX);
		run(CMD_TX_RX, 0, 1, EV_OK, 1, 0, OP_TX_RX);
		typea <= 1'b0;
		$display("test long frames done");
		ev(EV_USER_STOP, 0, 0, OP_TX_RX, 0, RC_HW_COMM);
		ev(EV_USER_STOP, 0, 1, OP_TX_RX, 0, RC_USER_ABORT);
		ev(EV_COMM, 0, 0, OP_TX_RX, 0, RC_HW_COMM);
		ev(EV_WAIT_TOUT, 0, 0, OP_TX_RX, 0, RC_WAIT_TOUT);
		ev(EV_BAD_START, 0, 0, OP_TX_RX, 0, RC_BAD_START);
		ev(EV_FRAMING, 0, 0, OP_TX_RX, 0, RC_FRAMING);
		ev(EV_GUARD, 0, 0, OP_TX_RX, 0, RC_GUARD_TOUT);
		ev(EV_CRC, 1, 0, OP_TX_RX, 0, RC_CRC_FAULT);
		ev(EV_CRC, 0, 0, OP_TX_RX, 2, 8'h00);
		ev(EV_OK, 1, 0, OP_TX_RX, 2, RC_BAD_LENGTH);
		ev(EV_OK, 1, 0, OP_TX_RX, 3, 8'h00);
		ev(EV_LOST, 0, 0, OP_TX_RX, 0, RC_RX_LOST);
		ev(EV_NO_FIELD, 0, 1, OP_LISTEN, 0, RC_NO_FIELD);
		ev(EV_NO_FIELD, 0, 0, OP_TX_RX, 0, RC_HW_COMM);
		$display("test result codes done");
		card <= 1'b1;
		cfg_evt <= EV_USER_STOP;
		cfg_cnt <= 10'd0;
		cur_len = 0;
		opq.push_back({8'h00, OP_LISTEN});
		send(CMD_LISTEN, 0, 0);
		send(CMD_ECHO, 0, 1);
		reply(RC_USER_ABORT, 0, 0);
		`CHK("eng_abort", 1, n_abort)
		$display("test listen abort done");
		apb(REG_SESSION, 1, {24'h0, CTL_RESET}, 0, 0);
		apb(REG_CLOSE, 1, 0, 0, 0);
		apb(REG_STATUS, 0, 0, 1, 32'h4);
		`CHK("dev_reset", 1, n_rst)
		`CHK("opq", 0, opq.size())
		$display("test device reset done");
		give_verdict;
	end
endmodule
`default_nettype wire
